//--- hdl/mcrs_card_regs.v
// Notes on behaviour
// - Hold a 128-bit identity register used during card identification.
// - Hold a 32-bit operating-conditions register with voltage windows and power-up flag.
// - Hold 128-bit card-specific data; only some fields rewritable, only by command 27.
// - Hold a 64-bit special-features register reporting optional capabilities.
// - Hold a 16-bit relative address; unavailable while the card runs in SPI mode.
// - Hold a 512-bit status block with card features and lifetime data.
// - Identity layout: maker, application, name, revision, serial, zeros, date, checksum, one.
// - Operating bits 0-14 read 0; window bits 15 to 23 read 1.
// - Operating bit 24 reads 1 for 1.8 V switching; bits 25-29 reserved.
// - Operating bit 30 is capacity status; bit 31 is ready, 0 meaning busy.
// - Ready bit stays low until the internal power-up routine has finished.
// - Access-time value 00001110 at 119:112, clock-cycle part zero at 111:104.
// - Transfer rate at 103:96: 00110010 default, 00101011 for SDR104.
// - Command-class mask 010110110101 at bits 95:84.
// - Read block length code 1001 at bits 83:80.
// - Bits 79 to 76 read zero: no partial, misaligned or driver-stage support.
// - Bit 46 reads 1 for single-block erase; sector size 1111111 at 45:39.
// - Protect group size zero at 38:32; group protect enable bit 31 zero.
`timescale 1ns/10ps
`include "mcrs_defines.vh"

module mcrs_card_regs #(
    parameter [7:0] MAKER_CODE = 8'h01,           // Arbitrary neutral value
    parameter [15:0] APP_CODE = 16'h4142,         // Arbitrary neutral value
    parameter [39:0] PRODUCT_NAME = 40'h41_4243_4445, // Arbitrary neutral value
    parameter [7:0] PRODUCT_REV = 8'h10,          // Arbitrary neutral value
    parameter [11:0] MAKE_DATE = 12'h0001         // Arbitrary neutral value
) (
    input wire i_sys_clk,
    input wire i_rst,
    input wire i_ce,
    input wire i_spi_mode,
    input wire i_power_up_done,
    input wire i_capacity_high,
    input wire i_sdr104_mode,
    input wire [21:0] i_device_size,
    input wire [31:0] i_serial_number,
    input wire i_rca_load,
    input wire [15:0] i_rca_value,
    input wire i_stat_wr,
    input wire [3:0] i_stat_word,
    input wire [31:0] i_stat_data,
    input wire i_rd_req,
    input wire [2:0] i_rd_sel,
    input wire [3:0] i_rd_word,
    input wire i_prog_req,
    input wire [5:0] i_prog_cmd,
    input wire [127:0] i_prog_data,
    output reg o_rd_valid,
    output reg [31:0] o_rd_data,
    output reg o_rd_error,
    output reg o_prog_done,
    output reg o_prog_error,
    output reg o_ready,
    output reg o_tmp_protect,
    output reg o_perm_protect
);

    // Checksum over a 120-bit message, most significant bit first
    // The caller appends the always-one bit below the checksum
    function [6:0] mcrs_crc7;
        input [119:0] msg;
        integer i;
        reg [6:0] crc;
        reg fb;
        begin
            crc = 7'h00;
            fb = 1'b0;
            for (i = `MCRS_CRC_MSG_W - 1; i >= 0; i = i - 1) begin
                fb = msg[i] ^ crc[6];
                crc = {crc[5:0], 1'b0};
                if (fb) begin
                    crc = crc ^ `MCRS_CRC_POLY;
                end
            end
            mcrs_crc7 = crc;
        end
    endfunction

    // Picks one 32-bit word out of a 128-bit register, word 0 lowest
    function [31:0] mcrs_pick128;
        input [127:0] val;
        input [1:0] idx;
        begin
            case (idx)
                2'h0: mcrs_pick128 = val[31:0];
                2'h1: mcrs_pick128 = val[63:32];
                2'h2: mcrs_pick128 = val[95:64];
                default: mcrs_pick128 = val[127:96];
            endcase
        end
    endfunction

    // Last legal word index of a register select
    function [3:0] mcrs_last_word;
        input [2:0] sel;
        begin
            case (sel)
                `MCRS_SEL_IDENT: mcrs_last_word = `MCRS_IDENT_LAST;
                `MCRS_SEL_OPCOND: mcrs_last_word = `MCRS_OPCOND_LAST;
                `MCRS_SEL_SPEC: mcrs_last_word = `MCRS_SPEC_LAST;
                `MCRS_SEL_FEAT: mcrs_last_word = `MCRS_FEAT_LAST;
                `MCRS_SEL_RCA: mcrs_last_word = `MCRS_RCA_LAST;
                default: mcrs_last_word = `MCRS_STAT_LAST;
            endcase
        end
    endfunction

    // Select decodes that exist as registers at all
    function mcrs_sel_known;
        input [2:0] sel;
        begin
            mcrs_sel_known = (sel <= `MCRS_SEL_STAT);
        end
    endfunction

    // Power-up, address and writable-field state
    reg ready_reg;
    reg ready_next;
    reg [15:0] rca_reg;
    reg fmt_grp_reg;
    reg copy_reg;
    reg perm_reg;
    reg tmp_reg;
    reg [1:0] fmt_reg;
    reg once_used_reg;
    // Status block words, word 0 holds bits 31:0
    reg [31:0] stat_mem [0:`MCRS_STAT_WORDS-1];
    // Loop index for clearing the status block
    integer k;

    // Assembled register images
    wire [119:0] ident_msg;
    wire [127:0] ident_val;
    wire [31:0] opcond_val;
    wire [14:0] oc_reserved_lo;
    wire [8:0] oc_windows;
    wire oc_switch_ok;
    wire [4:0] oc_reserved_hi;
    wire oc_capacity;
    wire [119:0] spec_msg;
    wire [127:0] spec_val;
    wire [63:0] feat_val;
    wire [7:0] rate_code;
    // Read and rewrite decode
    wire rd_sel_ok;
    wire rd_word_ok;
    wire rd_hidden;
    wire rd_legal;
    wire prog_legal;
    wire prog_take;
    wire once_open;
    // Word picked for the read port
    reg [31:0] rd_word_val;

    // Identity register, checksum and trailing one appended
    assign ident_msg = {MAKER_CODE, APP_CODE, PRODUCT_NAME, PRODUCT_REV, i_serial_number,
                        4'h0, MAKE_DATE};
    assign ident_val = {ident_msg, mcrs_crc7(ident_msg), 1'b1};

    // Reserved bits 0 to 3 and the low windows up to 2.7 V read zero
    assign oc_reserved_lo = `MCRS_OC_RSV_LO;
    // Windows from 2.7 V to 3.6 V in 0.1 V steps are all supported
    assign oc_windows = `MCRS_OC_WINDOWS;
    // Switching to 1.8 V signalling is accepted; bits 25 to 29 are reserved
    assign oc_switch_ok = `MCRS_OC_SWITCH;
    assign oc_reserved_hi = `MCRS_OC_RSV_HI;
    // Capacity status means nothing while busy, so it reads zero until ready
    assign oc_capacity = ready_reg & i_capacity_high;
    // Operating word, ready flag on top
    assign opcond_val = {ready_reg, oc_capacity, oc_reserved_hi, oc_switch_ok, oc_windows,
                         oc_reserved_lo};

    // Transfer rate follows the active bus mode
    assign rate_code = i_sdr104_mode ? `MCRS_RATE_SDR104 : `MCRS_RATE_DEF;

    // Card-specific data down to bit 8, reserved fields held at zero
    assign spec_msg = {
        `MCRS_LAYOUT_VER,
        6'h00,
        `MCRS_ACC_TIME,
        `MCRS_ACC_CYC,
        rate_code,
        `MCRS_CMD_CLASS,
        `MCRS_RD_BLK_LEN,
        4'h0,
        6'h00,
        i_device_size,
        1'b0,
        1'b1,
        `MCRS_ERASE_SECT,
        `MCRS_PROT_GRP,
        1'b0,
        2'h0,
        `MCRS_WR_FACTOR,
        `MCRS_WR_BLK_LEN,
        1'b0,
        5'h00,
        fmt_grp_reg,
        copy_reg,
        perm_reg,
        tmp_reg,
        fmt_reg,
        2'h0
    };
    assign spec_val = {spec_msg, mcrs_crc7(spec_msg), 1'b1};

    // Special-features content is fixed
    assign feat_val = `MCRS_FEAT_VALUE;

    // A read needs a known register and a word inside it
    assign rd_sel_ok = mcrs_sel_known(i_rd_sel);
    assign rd_word_ok = (i_rd_word <= mcrs_last_word(i_rd_sel));
    // The relative address does not exist while the card runs in SPI mode
    assign rd_hidden = i_spi_mode && (i_rd_sel == `MCRS_SEL_RCA);
    // Refused reads answer with an error and zero data
    assign rd_legal = rd_sel_ok && rd_word_ok && !rd_hidden;

    // Only the rewrite command reaches the writable fields
    assign prog_legal = (i_prog_cmd == `MCRS_CMD_REWRITE);
    assign prog_take = i_prog_req && prog_legal;
    // Once-only fields stay open until the first legal rewrite after reset
    assign once_open = prog_take && !once_used_reg;

    // Word selection for the read port
    always @* begin
        rd_word_val = 32'h0000_0000;
        case (i_rd_sel)
            `MCRS_SEL_IDENT: begin
                rd_word_val = mcrs_pick128(ident_val, i_rd_word[1:0]);
            end
            `MCRS_SEL_OPCOND: begin
                rd_word_val = opcond_val;
            end
            `MCRS_SEL_SPEC: begin
                rd_word_val = mcrs_pick128(spec_val, i_rd_word[1:0]);
            end
            `MCRS_SEL_FEAT: begin
                rd_word_val = i_rd_word[0] ? feat_val[63:32] : feat_val[31:0];
            end
            `MCRS_SEL_RCA: begin
                rd_word_val = {16'h0000, rca_reg};
            end
            `MCRS_SEL_STAT: begin
                rd_word_val = stat_mem[i_rd_word];
            end
            default: begin
                rd_word_val = 32'h0000_0000;
            end
        endcase
    end

    // Ready is sticky once power-up has finished, cleared only by reset
    always @* begin
        ready_next = ready_reg | i_power_up_done;
    end

    // Power-up state and published relative address
    always @(posedge i_sys_clk) begin
        if (i_rst) begin
            ready_reg <= 1'b0;
            rca_reg <= 16'h0000;
        end else if (i_ce) begin
            ready_reg <= ready_next;
            // Address loads are ignored in SPI mode, where it does not exist
            if (i_rca_load && !i_spi_mode) begin
                rca_reg <= i_rca_value;
            end
        end
    end

    // Status block, updated word by word by the card's own logic
    always @(posedge i_sys_clk) begin
        if (i_rst) begin
            for (k = 0; k < `MCRS_STAT_WORDS; k = k + 1) begin
                stat_mem[k] <= 32'h0000_0000;
            end
        end else if (i_ce && i_stat_wr) begin
            stat_mem[i_stat_word] <= i_stat_data;
        end
    end

    // Rewrite of the writable fields; once-only fields lock after the first rewrite
    always @(posedge i_sys_clk) begin
        if (i_rst) begin
            fmt_grp_reg <= 1'b0;
            copy_reg <= 1'b0;
            perm_reg <= 1'b0;
            tmp_reg <= 1'b0;
            fmt_reg <= 2'h0;
            once_used_reg <= 1'b0;
            o_prog_done <= 1'b0;
            o_prog_error <= 1'b0;
        end else if (i_ce) begin
            // Every request is answered; only a wrong command is flagged
            o_prog_done <= i_prog_req;
            o_prog_error <= i_prog_req && !prog_legal;
            if (prog_take) begin
                // Temporary protection follows every legal rewrite
                tmp_reg <= i_prog_data[`MCRS_TMP_BIT];
                if (once_open) begin
                    fmt_grp_reg <= i_prog_data[`MCRS_FMT_GRP_BIT];
                    copy_reg <= i_prog_data[`MCRS_COPY_BIT];
                    perm_reg <= i_prog_data[`MCRS_PERM_BIT];
                    fmt_reg <= i_prog_data[`MCRS_FMT_HI:`MCRS_FMT_LO];
                    once_used_reg <= 1'b1;
                end
                // Read-only bits of the written image are dropped here
            end
        end
    end

    // Read answer, one cycle after the request
    always @(posedge i_sys_clk) begin
        if (i_rst) begin
            o_rd_valid <= 1'b0;
            o_rd_data <= 32'h0000_0000;
            o_rd_error <= 1'b0;
        end else if (i_ce) begin
            o_rd_valid <= i_rd_req;
            o_rd_error <= i_rd_req && !rd_legal;
            // Data stands until the next taken read
            if (i_rd_req) begin
                o_rd_data <= rd_legal ? rd_word_val : 32'h0000_0000;
            end
        end
    end

    // Status outputs that steer the rest of the card
    always @(posedge i_sys_clk) begin
        if (i_rst) begin
            o_ready <= 1'b0;
            o_tmp_protect <= 1'b0;
            o_perm_protect <= 1'b0;
        end else if (i_ce) begin
            o_ready <= ready_reg;
            o_tmp_protect <= tmp_reg;
            o_perm_protect <= perm_reg;
        end
    end

endmodule // mcrs_card_regs

//--- common/mcrs_defines.vh
`ifndef MCRS_DEFINES_VH
`define MCRS_DEFINES_VH

// Register widths
`define MCRS_IDENT_W 128
`define MCRS_OPCOND_W 32
`define MCRS_SPEC_W 128
`define MCRS_FEAT_W 64
`define MCRS_RCA_W 16
`define MCRS_STAT_W 512
`define MCRS_WORD_W 32
`define MCRS_STAT_WORDS 16

// Register selects on the read port
`define MCRS_SEL_IDENT 3'h0
`define MCRS_SEL_OPCOND 3'h1
`define MCRS_SEL_SPEC 3'h2
`define MCRS_SEL_FEAT 3'h3
`define MCRS_SEL_RCA 3'h4
`define MCRS_SEL_STAT 3'h5

// Last word index of each register
`define MCRS_IDENT_LAST 4'h3
`define MCRS_OPCOND_LAST 4'h0
`define MCRS_SPEC_LAST 4'h3
`define MCRS_FEAT_LAST 4'h1
`define MCRS_RCA_LAST 4'h0
`define MCRS_STAT_LAST 4'hf

// Command that rewrites the card-specific data
`define MCRS_CMD_REWRITE 6'h1b

// Fixed card-specific data fields
`define MCRS_LAYOUT_VER 2'h1
`define MCRS_ACC_TIME 8'h0e
`define MCRS_ACC_CYC 8'h00
`define MCRS_RATE_DEF 8'h32
`define MCRS_RATE_SDR104 8'h2b
`define MCRS_CMD_CLASS 12'h05b5
`define MCRS_RD_BLK_LEN 4'h9
`define MCRS_WR_BLK_LEN 4'h9
`define MCRS_ERASE_SECT 7'h7f
`define MCRS_PROT_GRP 7'h00
`define MCRS_WR_FACTOR 3'h2

// Writable field positions in the card-specific data
`define MCRS_FMT_GRP_BIT 15
`define MCRS_COPY_BIT 14
`define MCRS_PERM_BIT 13
`define MCRS_TMP_BIT 12
`define MCRS_FMT_HI 11
`define MCRS_FMT_LO 10

// Operating conditions: windows 2.7-3.6 V and 1.8 V switch accepted
`define MCRS_OC_RSV_LO 15'h0000
`define MCRS_OC_WINDOWS 9'h1ff
`define MCRS_OC_SWITCH 1'b1
`define MCRS_OC_RSV_HI 5'h00
`define MCRS_OC_CAP_BIT 30
`define MCRS_OC_READY_BIT 31

// Special-features register content
`define MCRS_FEAT_VALUE 64'h0205_8483_0000_0000

// Checksum polynomial x^7 + x^3 + 1
`define MCRS_CRC_POLY 7'h09
`define MCRS_CRC_MSG_W 120

`endif

//--- tb/mcrs_card_regs_assertions.sv
`timescale 1ns/10ps
module mcrs_card_regs_assertions (
    input wire i_sys_clk,
    input wire i_rst,
    input wire i_ce,
    input wire i_power_up_done,
    input wire i_capacity_high,
    input wire i_sdr104_mode,
    input wire i_spi_mode,
    input wire i_rd_req,
    input wire [2:0] i_rd_sel,
    input wire [3:0] i_rd_word,
    input wire i_prog_req,
    input wire [5:0] i_prog_cmd,
    input wire o_rd_valid,
    input wire [31:0] o_rd_data,
    input wire o_rd_error,
    input wire o_prog_done,
    input wire o_prog_error,
    input wire o_ready
);
    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (i_rst);
    // Reads of the operating word and of the top card-specific word
    sequence s_opc_rd;
        i_ce && i_rd_req && i_rd_sel == 3'h1 && i_rd_word == 4'h0;
    endsequence
    sequence s_spec3_rd;
        i_ce && i_rd_req && i_rd_sel == 3'h2 && i_rd_word == 4'h3;
    endsequence
    property p_rd_answer;
        i_ce && i_rd_req |=> o_rd_valid;
    endproperty
    a_rd_answer: assert property (p_rd_answer) else $error("read not answered");
    property p_opc_fixed;
        s_opc_rd |=> o_rd_data[29:0] == 30'h01ff_8000 && !o_rd_error;
    endproperty
    a_opc_fixed: assert property (p_opc_fixed) else $error("voltage windows wrong");
    property p_opc_busy;
        s_opc_rd ##0 (!o_ready && !i_power_up_done && !$past(i_power_up_done)) |=> o_rd_data[31:30] == 2'b00;
    endproperty
    a_opc_busy: assert property (p_opc_busy) else $error("ready before power-up");
    property p_opc_ready;
        s_opc_rd ##0 o_ready |=> o_rd_data[31] && o_rd_data[30] == $past(i_capacity_high);
    endproperty
    a_opc_ready: assert property (p_opc_ready) else $error("ready or capacity wrong");
    property p_rca_spi;
        i_ce && i_rd_req && i_rd_sel == 3'h4 && i_spi_mode |=> o_rd_error && o_rd_data == 32'h0000_0000;
    endproperty
    a_rca_spi: assert property (p_rca_spi) else $error("address readable in SPI mode");
    property p_spec_time;
        s_spec3_rd |=> o_rd_data[31:8] == 24'h40_0e00;
    endproperty
    a_spec_time: assert property (p_spec_time) else $error("access time wrong");
    property p_spec_rate;
        s_spec3_rd |=> o_rd_data[7:0] == ($past(i_sdr104_mode) ? 8'h2b : 8'h32);
    endproperty
    a_spec_rate: assert property (p_spec_rate) else $error("transfer rate wrong");
    property p_prog_bad;
        i_ce && i_prog_req && i_prog_cmd != 6'h1b |=> o_prog_done && o_prog_error;
    endproperty
    a_prog_bad: assert property (p_prog_bad) else $error("bad command accepted");
    property p_prog_ok;
        i_ce && i_prog_req && i_prog_cmd == 6'h1b |=> o_prog_done && !o_prog_error;
    endproperty
    a_prog_ok: assert property (p_prog_ok) else $error("rewrite refused");
endmodule // mcrs_card_regs_assertions

bind mcrs_card_regs mcrs_card_regs_assertions mcrs_card_regs_assertions_i (
    .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_ce(i_ce), .i_power_up_done(i_power_up_done),
    .i_capacity_high(i_capacity_high), .i_sdr104_mode(i_sdr104_mode), .i_spi_mode(i_spi_mode),
    .i_rd_req(i_rd_req), .i_rd_sel(i_rd_sel), .i_rd_word(i_rd_word), .i_prog_req(i_prog_req),
    .i_prog_cmd(i_prog_cmd), .o_rd_valid(o_rd_valid), .o_rd_data(o_rd_data), .o_rd_error(o_rd_error),
    .o_prog_done(o_prog_done), .o_prog_error(o_prog_error), .o_ready(o_ready));

//--- tb/mcrs_host_model.sv
`timescale 1ns/10ps
module mcrs_host_model (
    input wire i_sys_clk,
    input wire i_rd_valid,
    input wire [31:0] i_rd_data,
    input wire i_rd_error,
    input wire i_prog_done,
    input wire i_prog_error,
    output reg o_rd_req = 1'b0,
    output reg [2:0] o_rd_sel = 3'h0,
    output reg [3:0] o_rd_word = 4'h0,
    output reg o_prog_req = 1'b0,
    output reg [5:0] o_prog_cmd = 6'h00,
    output reg [127:0] o_prog_data = 128'h0
);
    // One read; a missing answer comes back unknown
    task rd(input [2:0] s, input [3:0] w, output [31:0] d, output e);
        begin
            @(posedge i_sys_clk) #1;
            o_rd_req = 1'b1;
            o_rd_sel = s;
            o_rd_word = w;
            @(posedge i_sys_clk) #1;
            o_rd_req = 1'b0;
            o_rd_sel = ~s; // Released lines do not keep their value
            o_rd_word = ~w;
            d = i_rd_valid ? i_rd_data : 32'hxxxx_xxxx;
            e = i_rd_valid ? i_rd_error : 1'bx;
        end
    endtask
    // Capacity flag is trusted only once the card reports ready
    task cap(output c);
        reg [31:0] d;
        reg e;
        begin
            rd(3'h1, 4'h0, d, e);
            c = d[31] ? d[30] : 1'bx;
        end
    endtask
    // User capacity in kilobytes: device size plus one, times 512
    task capacity(output [31:0] kb);
        reg [31:0] w1;
        reg [31:0] w2;
        reg e;
        begin
            rd(3'h2, 4'h2, w2, e);
            rd(3'h2, 4'h1, w1, e);
            kb = ({10'h000, w2[5:0], w1[31:16]} + 32'h0000_0001) * 32'h0000_0200;
        end
    endtask
    // Rewrite of the card-specific data with a given command code
    task prog(input [5:0] c, input [127:0] v, output e);
        begin
            @(posedge i_sys_clk) #1;
            o_prog_req = 1'b1;
            o_prog_cmd = c;
            o_prog_data = v;
            @(posedge i_sys_clk) #1;
            o_prog_req = 1'b0;
            o_prog_data = ~v;
            e = i_prog_done ? i_prog_error : 1'bx;
        end
    endtask
endmodule // mcrs_host_model

//--- tb/testbench.sv
`timescale 1ns/10ps
module testbench;
    reg i_sys_clk = 1'b0, i_rst = 1'b1, i_spi_mode = 1'b0, i_power_up_done = 1'b0;
    reg i_capacity_high = 1'b0, i_sdr104_mode = 1'b0, i_rca_load = 1'b0, i_stat_wr = 1'b0;
    reg [21:0] i_device_size = 22'h3a_bcde;
    reg [31:0] i_serial_number = 32'hcafe_0123, i_stat_data = 32'h0000_0000, d;
    reg [15:0] i_rca_value = 16'h0000;
    reg [3:0] i_stat_word = 4'h0;
    reg e;
    reg i_ce = 1'b1;
    reg [6:0] c7;
    integer err_total = 0, comparisons = 0, cyc = 0;
    wire rq, vl, er, pq, pd, pe, rdy, tp, pp;
    wire [2:0] sl;
    wire [3:0] wd;
    wire [5:0] pc;
    wire [31:0] dat;
    wire [127:0] pdt;
    mcrs_card_regs mcrs_card_regs_i (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_ce(i_ce),
        .i_spi_mode(i_spi_mode), .i_power_up_done(i_power_up_done), .i_capacity_high(i_capacity_high),
        .i_sdr104_mode(i_sdr104_mode), .i_device_size(i_device_size), .i_serial_number(i_serial_number),
        .i_rca_load(i_rca_load), .i_rca_value(i_rca_value), .i_stat_wr(i_stat_wr), .i_stat_word(i_stat_word),
        .i_stat_data(i_stat_data), .i_rd_req(rq), .i_rd_sel(sl), .i_rd_word(wd), .i_prog_req(pq),
        .i_prog_cmd(pc), .i_prog_data(pdt), .o_rd_valid(vl), .o_rd_data(dat), .o_rd_error(er),
        .o_prog_done(pd), .o_prog_error(pe), .o_ready(rdy), .o_tmp_protect(tp), .o_perm_protect(pp));
    mcrs_host_model mcrs_host_model_i (.i_sys_clk(i_sys_clk), .i_rd_valid(vl), .i_rd_data(dat),
        .i_rd_error(er), .i_prog_done(pd), .i_prog_error(pe), .o_rd_req(rq), .o_rd_sel(sl),
        .o_rd_word(wd), .o_prog_req(pq), .o_prog_cmd(pc), .o_prog_data(pdt));
    // Clock and hang guard
    always #5 i_sys_clk = ~i_sys_clk;
    always @(posedge i_sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            err_total = err_total + 1;
            report_and_stop;
        end
    end
    // Compare one value and count it
    task chk(input string nm, input [31:0] got, input [31:0] exp);
        begin
            comparisons = comparisons + 1;
            if (got !== exp) begin
                err_total = err_total + 1;
                $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
            end
        end
    endtask
    // Reference checksum x^7 + x^3 + 1 over a 120-bit message, top bit first
    function [6:0] crc_ref(input [119:0] m);
        integer n;
        begin
            crc_ref = 7'h00;
            for (n = 119; n >= 0; n = n - 1)
                crc_ref = {crc_ref[5:3], crc_ref[2] ^ crc_ref[6] ^ m[n], crc_ref[1:0], crc_ref[6] ^ m[n]};
        end
    endfunction
    task tick;
        @(posedge i_sys_clk) #1;
    endtask
    task r(input [2:0] s, input [3:0] w);
        mcrs_host_model_i.rd(s, w, d, e);
    endtask
    // Operating word before and after power-up
    task t_opcond;
        begin
            r(3'h1, 4'h0);
            chk("oc_busy", d, 32'h01ff_8000);
            chk("rdy0", {31'h0, rdy}, 32'h0);
            r(3'h1, 4'h1);
            chk("oc_w1", {31'h0, e}, 32'h1);
            i_power_up_done = 1'b1;
            i_capacity_high = 1'b1;
            tick;
            i_power_up_done = 1'b0;
            r(3'h1, 4'h0);
            chk("oc_rdy", d, 32'hc1ff_8000);
            chk("oc_v18", {31'h0, d[24]}, 32'h1);
            mcrs_host_model_i.cap(e);
            chk("cap", {31'h0, e}, 32'h1);
            chk("rdy1", {31'h0, rdy}, 32'h1);
        end
    endtask
    // Identity words and the word beyond its end
    task t_ident;
        begin
            r(3'h0, 4'h3);
            chk("id3", d, 32'h0141_4241);
            r(3'h0, 4'h2);
            chk("id2", d, 32'h4243_4445);
            r(3'h0, 4'h1);
            chk("id1", d, 32'h10ca_fe01);
            r(3'h0, 4'h0);
            chk("id0", {d[31:8], 7'h0, d[0]}, 32'h2300_0101);
            c7 = crc_ref({32'h0141_4241, 32'h4243_4445, 32'h10ca_fe01, 24'h23_0001});
            chk("id_crc", {25'h0, d[7:1]}, {25'h0, c7});
            r(3'h0, 4'h4);
            chk("id4", {31'h0, e}, 32'h1);
        end
    endtask
    // Card-specific words, word 3 at both transfer rates and the rest at SDR104
    task t_spec;
        begin
            r(3'h2, 4'h3);
            chk("sp3", d, 32'h400e_0032);
            i_sdr104_mode = 1'b1;
            r(3'h2, 4'h3);
            chk("sp3f", d, 32'h400e_002b);
            r(3'h2, 4'h2);
            chk("sp2", d, 32'h5b59_003a);
            r(3'h2, 4'h1);
            chk("sp1", d, 32'hbcde_7f80);
            r(3'h2, 4'h0);
            chk("sp0", {d[31:8], 7'h0, d[0]}, 32'h0a40_0001);
            c7 = crc_ref({32'h400e_002b, 32'h5b59_003a, 32'hbcde_7f80, 24'h0a_4000});
            chk("sp_crc", {25'h0, d[7:1]}, {25'h0, c7});
            mcrs_host_model_i.capacity(d);
            chk("cap_kb", d, 32'h7579_be00);
        end
    endtask
    // Rewrites: wrong command, first legal, second legal
    task t_prog;
        begin
            mcrs_host_model_i.prog(6'h1a, {128{1'b1}}, e);
            chk("pg_bad", {31'h0, e}, 32'h1);
            r(3'h2, 4'h0);
            chk("pg_keep", {d[31:8], 7'h0, d[0]}, 32'h0a40_0001);
            mcrs_host_model_i.prog(6'h1b, {128{1'b1}}, e);
            chk("pg_ok", {31'h0, e}, 32'h0);
            r(3'h2, 4'h0);
            chk("pg_w0", {d[31:8], 7'h0, d[0]}, 32'h0a40_fc01);
            r(3'h2, 4'h3);
            chk("pg_ro", d, 32'h400e_002b);
            chk("pg_pt", {30'h0, pp, tp}, 32'h3);
            mcrs_host_model_i.prog(6'h1b, 128'h0, e);
            r(3'h2, 4'h0);
            chk("pg_once", {d[31:8], 7'h0, d[0]}, 32'h0a40_ec01);
            chk("pg_pt2", {30'h0, pp, tp}, 32'h2);
        end
    endtask
    // Relative address in both modes, then an unknown select
    task t_rca;
        begin
            i_rca_value = 16'h1234;
            i_rca_load = 1'b1;
            tick;
            i_spi_mode = 1'b1;
            i_rca_value = 16'h5555;
            tick;
            i_rca_load = 1'b0;
            r(3'h4, 4'h0);
            chk("rca_spi", {31'h0, e}, 32'h1);
            i_spi_mode = 1'b0;
            r(3'h4, 4'h0);
            chk("rca", d, 32'h0000_1234);
            r(3'h6, 4'h0);
            chk("sel6", {31'h0, e}, 32'h1);
        end
    endtask
    // Status block writes and the feature register
    task t_stat;
        begin
            i_stat_wr = 1'b1;
            i_stat_word = 4'hf;
            i_stat_data = 32'ha5a5_0f0f;
            tick;
            i_stat_wr = 1'b0;
            r(3'h5, 4'hf);
            chk("st15", d, 32'ha5a5_0f0f);
            r(3'h5, 4'h0);
            chk("st0", d, 32'h0000_0000);
            r(3'h3, 4'h1);
            chk("ft1", d, 32'h0205_8483);
            r(3'h3, 4'h2);
            chk("ft2", {31'h0, e}, 32'h1);
        end
    endtask
    // Clock enable low: no read answer and no status write
    task t_ce;
        begin
            tick;
            i_ce = 1'b0;
            i_stat_wr = 1'b1;
            i_stat_data = 32'h5a5a_1234;
            r(3'h5, 4'hf);
            chk("ce_vl", {31'h0, vl}, 32'h0);
            i_stat_wr = 1'b0;
            i_ce = 1'b1;
            r(3'h5, 4'hf);
            chk("ce_st", d, 32'ha5a5_0f0f);
        end
    endtask
    // Reset in mid-run clears power-up, status, address and the once-only lock
    task t_reset;
        begin
            i_rst = 1'b1;
            tick;
            i_rst = 1'b0;
            r(3'h1, 4'h0);
            chk("rs_oc", d, 32'h01ff_8000);
            chk("rs_rdy", {31'h0, rdy}, 32'h0);
            r(3'h5, 4'hf);
            chk("rs_st", d, 32'h0000_0000);
            r(3'h4, 4'h0);
            chk("rs_rca", d, 32'h0000_0000);
            r(3'h2, 4'h0);
            chk("rs_sp0", {d[31:8], 7'h0, d[0]}, 32'h0a40_0001);
            mcrs_host_model_i.prog(6'h1b, {128{1'b1}}, e);
            r(3'h2, 4'h0);
            chk("rs_once", {d[31:8], 7'h0, d[0]}, 32'h0a40_fc01);
        end
    endtask
    task report_and_stop;
        begin
            $display("Checks %0d, mismatches %0d", comparisons, err_total);
            if (err_total == 0 && comparisons > 0)
                $display("Regression OK");
            else
                $display("Regression broken");
            $finish;
        end
    endtask
    initial begin
        repeat (3) @(posedge i_sys_clk);
        #1;
        i_rst = 1'b0;
        t_opcond;
        t_ident;
        t_spec;
        t_prog;
        t_rca;
        t_stat;
        t_ce;
        t_reset;
        report_and_stop;
    end
endmodule // testbench
